// [ddrsp_map.svh]
`ifndef DDRSP_MAP_SVH
`define DDRSP_MAP_SVH

// data and address shape
`define DDRSP_DATA_W      36
`define DDRSP_LANE_W      9
`define DDRSP_LANES       4
`define DDRSP_ADDR_W      19
`define DDRSP_FIFO_DEPTH  16
// read schedule, in half cycles after the command edge
`define DDRSP_RSCHED_W    6
`define DDRSP_RPUSH0      0
`define DDRSP_RPUSH1      1
`define DDRSP_RVALID0     3
`define DDRSP_RPOP0       4
`define DDRSP_RPOP1       5
// write schedule, in half cycles after the command edge
`define DDRSP_WSCHED_W    3
`define DDRSP_WCAP0       1
`define DDRSP_WCAP1       2
// lane select pattern values
`define DDRSP_MASK_ALL    4'h0
`define DDRSP_MASK_NONE   4'hf
`endif

// [ddrsp_pkg.sv]
`include "ddrsp_map.svh"
package ddrsp_pkg;
	// phase of the next mclk edge: K rise or K# rise
	typedef enum logic [1:0] {
		PH_K  = 2'b01,
		PH_KN = 2'b10
	} ddrsp_phase_e;
	typedef logic [`DDRSP_DATA_W-1:0] ddrsp_word_t;
	typedef logic [`DDRSP_LANES-1:0]  ddrsp_mask_t;
endpackage : ddrsp_pkg

// [ddrsp_port.sv]
`include "ddrsp_map.svh"

// ----------------------------------------------------------------
// read data fifo
// ----------------------------------------------------------------
module ddrsp_fifo #(
	parameter int WIDTH = `DDRSP_DATA_W,
	parameter int DEPTH = `DDRSP_FIFO_DEPTH
) (
	input  wire logic             mclk,      // core clock
	input  wire logic             resetn,    // async reset, low
	input  wire logic             in_valid,  // push request
	output logic                  in_ready,  // room for a word
	input  wire logic [WIDTH-1:0] in_data,   // pushed word
	output logic                  out_valid, // word available
	input  wire logic             out_ready, // pop request
	output logic [WIDTH-1:0]      out_data   // head word
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
	logic [PW:0]      cnt_r, cnt_nxt;
	logic             do_push, do_pop;

	// pointer and count update
	always_comb begin
		do_push   = in_valid && in_ready;
		do_pop    = out_ready && out_valid;
		wp_nxt    = do_push ? wp_r + 1'b1 : wp_r;
		rp_nxt    = do_pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt   = cnt_r + {{PW{1'b0}}, do_push} - {{PW{1'b0}}, do_pop};
		in_ready  = (cnt_r != DEPTH[PW:0]);
		out_valid = (cnt_r != '0);
		out_data  = mem_r[rp_r];
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// storage holds no reset; only counted words are ever read
	always_ff @(posedge mclk) begin
		if (do_push) begin
			mem_r[wp_r] <= in_data;
		end
	end
endmodule : ddrsp_fifo

// ----------------------------------------------------------------
// burst port: each mclk edge is one K or K# rise
// ----------------------------------------------------------------
module ddrsp_port #(
	parameter int ADDR_W     = `DDRSP_ADDR_W,
	parameter int FIFO_DEPTH = `DDRSP_FIFO_DEPTH
) (
	input  wire logic                    mclk,                // core clock
	input  wire logic                    resetn,              // async, low
	input  wire logic                    load_strobe_n,       // command
	input  wire logic                    rw_sel,              // 1 read
	input  wire logic [ADDR_W-1:0]       addr,                // burst addr
	input  wire ddrsp_pkg::ddrsp_mask_t  byte_lane_select_n,  // lanes
	input  wire ddrsp_pkg::ddrsp_word_t  dq_in,               // data in
	output ddrsp_pkg::ddrsp_word_t       dq_out,              // data out
	output logic                         dq_oe,               // drive dq
	output logic                         output_valid_flag,   // lead flag
	output logic                         echo_clk             // K phase
);
	localparam int WI = ADDR_W + 1;
	localparam int MEM_N = 1 << WI;

	ddrsp_pkg::ddrsp_phase_e          phase_r, phase_nxt;
	logic [`DDRSP_RSCHED_W-1:0]       rsched_r, rsched_nxt;
	logic [`DDRSP_WSCHED_W-1:0]       wsched_r, wsched_nxt;
	logic [ADDR_W-1:0]                rd_addr_r, rd_addr_nxt;
	logic [ADDR_W-1:0]                wr_addr_r, wr_addr_nxt;
	logic [ADDR_W-1:0]                pend_addr_r, pend_addr_nxt;
	ddrsp_pkg::ddrsp_word_t           pend_dat_r [2];
	ddrsp_pkg::ddrsp_word_t           pend_dat_nxt [2];
	ddrsp_pkg::ddrsp_mask_t           pend_msk_r [2];
	ddrsp_pkg::ddrsp_mask_t           pend_msk_nxt [2];
	logic [1:0]                       pend_v_r, pend_v_nxt;
	ddrsp_pkg::ddrsp_word_t           dq_out_r, dq_out_nxt;
	logic                             dq_oe_r, dq_oe_nxt;
	logic                             valid_r, valid_nxt;
	logic                             echo_r, echo_nxt;
	ddrsp_pkg::ddrsp_word_t           mem_r [MEM_N];
	logic                             k_edge, rd_take, wr_take;
	logic                             cap0, cap1, commit_en;
	logic                             push_v, push_b, pop_req;
	logic [WI-1:0]                    push_idx, widx0, widx1;
	ddrsp_pkg::ddrsp_word_t           push_data, fifo_dout;
	logic                             fifo_in_ready, fifo_out_valid;

	// overwrite only the lanes whose active-low select is low
	function automatic ddrsp_pkg::ddrsp_word_t lane_merge(
		input ddrsp_pkg::ddrsp_word_t old_w,
		input ddrsp_pkg::ddrsp_word_t new_w,
		input ddrsp_pkg::ddrsp_mask_t sel_n
	);
		ddrsp_pkg::ddrsp_word_t res;
		res = old_w;
		for (int i = 0; i < `DDRSP_LANES; i++) begin
			if (!sel_n[i]) begin
				res[i*`DDRSP_LANE_W +: `DDRSP_LANE_W] =
					new_w[i*`DDRSP_LANE_W +: `DDRSP_LANE_W];
			end
		end
		return res;
	endfunction : lane_merge

	// word index: burst address plus word-in-burst bit
	function automatic logic [WI-1:0] word_idx(
		input logic [ADDR_W-1:0] a,
		input logic              b
	);
		return {a, b};
	endfunction : word_idx

	// ------------------------------------------------------------
	// command decode and schedules
	// ------------------------------------------------------------
	// a full fifo stalls read acceptance; with 16 words it never
	// fills at the fastest legal read rate
	always_comb begin
		k_edge   = (phase_r == ddrsp_pkg::PH_K);
		rd_take  = k_edge && !load_strobe_n && rw_sel
			&& fifo_in_ready;
		wr_take  = k_edge && !load_strobe_n && !rw_sel;
		unique case (phase_r)
			ddrsp_pkg::PH_K:  phase_nxt = ddrsp_pkg::PH_KN;
			ddrsp_pkg::PH_KN: phase_nxt = ddrsp_pkg::PH_K;
		endcase
		rsched_nxt  = {rsched_r[`DDRSP_RSCHED_W-2:0], rd_take};
		wsched_nxt  = {wsched_r[`DDRSP_WSCHED_W-2:0], wr_take};
		rd_addr_nxt = rd_take ? addr : rd_addr_r;
		wr_addr_nxt = wr_take ? addr : wr_addr_r;
	end

	// ------------------------------------------------------------
	// posted write registers
	// ------------------------------------------------------------
	// the previous write commits at the next write's first data edge,
	// so back-to-back writes never collide with the capture window
	always_comb begin
		cap0          = wsched_r[`DDRSP_WCAP0];
		cap1          = wsched_r[`DDRSP_WCAP1];
		commit_en     = cap0 && (pend_v_r != 2'b00);
		widx0         = word_idx(pend_addr_r, 1'b0);
		widx1         = word_idx(pend_addr_r, 1'b1);
		pend_addr_nxt = pend_addr_r;
		pend_dat_nxt  = pend_dat_r;
		pend_msk_nxt  = pend_msk_r;
		pend_v_nxt    = pend_v_r;
		if (cap0) begin
			pend_addr_nxt   = wr_addr_r;
			pend_dat_nxt[0] = dq_in;
			pend_msk_nxt[0] = byte_lane_select_n;
			pend_v_nxt      = 2'b01;
		end
		if (cap1) begin
			pend_dat_nxt[1] = dq_in;
			pend_msk_nxt[1] = byte_lane_select_n;
			pend_v_nxt[1]   = 1'b1;
		end
	end

	// array write; selects all high leave every lane untouched
	always_ff @(posedge mclk) begin
		if (commit_en && pend_v_r[0]) begin
			mem_r[widx0] <= lane_merge(mem_r[widx0], pend_dat_r[0],
				pend_msk_r[0]);
		end
		if (commit_en && pend_v_r[1]) begin
			mem_r[widx1] <= lane_merge(mem_r[widx1], pend_dat_r[1],
				pend_msk_r[1]);
		end
	end

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		push_v    = rsched_r[`DDRSP_RPUSH0] | rsched_r[`DDRSP_RPUSH1];
		push_b    = rsched_r[`DDRSP_RPUSH1];
		push_idx  = word_idx(rd_addr_r, push_b);
		push_data = mem_r[push_idx];
		if (pend_v_r[push_b] && pend_addr_r == rd_addr_r) begin
			push_data = lane_merge(push_data, pend_dat_r[push_b],
				pend_msk_r[push_b]);
		end
		pop_req    = rsched_r[`DDRSP_RPOP0] | rsched_r[`DDRSP_RPOP1];
		dq_out_nxt = (pop_req && fifo_out_valid) ? fifo_dout
			: dq_out_r;
		dq_oe_nxt  = pop_req;
		valid_nxt  = rsched_r[`DDRSP_RVALID0]
			| rsched_r[`DDRSP_RPOP0];
		echo_nxt   = k_edge;
	end

	ddrsp_fifo #(
		.WIDTH (`DDRSP_DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_rd_fifo (
		.mclk      (mclk),
		.resetn    (resetn),
		.in_valid  (push_v),
		.in_ready  (fifo_in_ready),
		.in_data   (push_data),
		.out_valid (fifo_out_valid),
		.out_ready (pop_req),
		.out_data  (fifo_dout)
	);

	// state registers; a stopped mclk simply holds them all
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			phase_r     <= ddrsp_pkg::PH_K;
			rsched_r    <= '0;
			wsched_r    <= '0;
			rd_addr_r   <= '0;
			wr_addr_r   <= '0;
			pend_addr_r <= '0;
			pend_dat_r  <= '{default: '0};
			pend_msk_r  <= '{default: `DDRSP_MASK_NONE};
			pend_v_r    <= 2'b00;
			dq_out_r    <= '0;
			dq_oe_r     <= 1'b0;
			valid_r     <= 1'b0;
			echo_r      <= 1'b0;
		end else begin
			phase_r     <= phase_nxt;
			rsched_r    <= rsched_nxt;
			wsched_r    <= wsched_nxt;
			rd_addr_r   <= rd_addr_nxt;
			wr_addr_r   <= wr_addr_nxt;
			pend_addr_r <= pend_addr_nxt;
			pend_dat_r  <= pend_dat_nxt;
			pend_msk_r  <= pend_msk_nxt;
			pend_v_r    <= pend_v_nxt;
			dq_out_r    <= dq_out_nxt;
			dq_oe_r     <= dq_oe_nxt;
			valid_r     <= valid_nxt;
			echo_r      <= echo_nxt;
		end
	end

	assign dq_out            = dq_out_r;
	assign dq_oe             = dq_oe_r;
	assign output_valid_flag = valid_r;
	assign echo_clk          = echo_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_read_latency : assert property (@(posedge mclk)
		disable iff (!resetn) rd_take |-> ##6 dq_oe_r ##1 dq_oe_r)
		else $error("read data not driven 2.5 cycles after command");
	chk_valid_lead : assert property (@(posedge mclk)
		disable iff (!resetn) $rose(dq_oe_r) |-> $past(valid_r))
		else $error("valid flag did not lead data by half a cycle");
	chk_idle_hiz : assert property (@(posedge mclk)
		disable iff (!resetn)
		$rose(dq_oe_r) |-> $past(rd_take, 6))
		else $error("data driven without a read command");
	chk_phase_alt : assert property (@(posedge mclk)
		disable iff (!resetn) $past(resetn) |-> phase_r != $past(phase_r))
		else $error("clock phases did not alternate");
	chk_write_capture : assert property (@(posedge mclk)
		disable iff (!resetn)
		wr_take |-> ##3 pend_v_r == 2'b01 ##1 pend_v_r == 2'b11)
		else $error("write words not captured at t+1 edges");
	chk_commit_full : assert property (@(posedge mclk)
		disable iff (!resetn)
		commit_en && pend_v_r[0] && pend_msk_r[0] == `DDRSP_MASK_ALL
		|=> mem_r[$past(widx0)] == $past(pend_dat_r[0]))
		else $error("full-lane write did not store the whole word");
	chk_commit_none : assert property (@(posedge mclk)
		disable iff (!resetn)
		commit_en && pend_v_r[1] && pend_msk_r[1] == `DDRSP_MASK_NONE
		|=> mem_r[$past(widx1)] == $past(mem_r[widx1]))
		else $error("masked write half altered memory");
	chk_forward_new : assert property (@(posedge mclk)
		disable iff (!resetn)
		push_v && pend_v_r[push_b] && pend_addr_r == rd_addr_r
		&& pend_msk_r[push_b] == `DDRSP_MASK_ALL
		|-> push_data == pend_dat_r[push_b])
		else $error("read of pending address missed newest data");
	chk_posted_hold : assert property (@(posedge mclk)
		disable iff (!resetn)
		pend_v_r[1] && !cap0 |=> pend_v_r == 2'b11 && $stable(pend_addr_r))
		else $error("posted write dropped before next write");
endmodule : ddrsp_port

// [ddrsp_master_model.sv]
// ----------------------------------------------------------------
// bus master model: drives commands and write data at falling edges
// ----------------------------------------------------------------
module ddrsp_master_model #(
	parameter int ADDR_W = 4
) (
	input  wire logic              mclk,               // core clock
	output logic                   load_strobe_n,      // command strobe
	output logic                   rw_sel,             // 1 read
	output logic [ADDR_W-1:0]      addr,               // burst address
	output ddrsp_pkg::ddrsp_mask_t byte_lane_select_n, // lane selects
	output ddrsp_pkg::ddrsp_word_t dq_in               // write data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_rd;

	// deselected at power up
	initial begin
		load_strobe_n = 1'b1;
		rw_sel = 1'b0;
		addr = '0;
		byte_lane_select_n = 4'hf;
		dq_in = '0;
		last_rd = 1'b0;
	end

	// one k cycle; called at the falling edge before a k rise
	task automatic slot(input logic ld, rw, input logic [ADDR_W-1:0] a,
		input ddrsp_pkg::ddrsp_word_t d0, d1,
		input ddrsp_pkg::ddrsp_mask_t m0, m1);
		load_strobe_n = ld;
		rw_sel = rw;
		addr = a;
		dq_in = d0;
		byte_lane_select_n = m0;
		@(negedge mclk);
		rw_sel = ~rw; // ignored at the k# rise
		dq_in = d1;
		byte_lane_select_n = m1;
		@(negedge mclk);
	endtask : slot

	// unused data lines toggle so a stale value never looks valid
	task automatic idle();
		slot(1'b1, ~rw_sel, ~addr, ~dq_in, dq_in, 4'h5, 4'ha);
	endtask : idle

	task automatic write(input logic [ADDR_W-1:0] a,
		input ddrsp_pkg::ddrsp_word_t w0, input ddrsp_pkg::ddrsp_mask_t m0,
		input ddrsp_pkg::ddrsp_word_t w1, input ddrsp_pkg::ddrsp_mask_t m1);
		if (last_rd)
			repeat (2) idle();
		slot(1'b0, 1'b0, a, ~dq_in, dq_in, 4'h5, 4'ha);
		slot(1'b1, 1'b1, ~a, w0, w1, m0, m1);
		last_rd = 1'b0;
	endtask : write

	task automatic read(input logic [ADDR_W-1:0] a);
		slot(1'b0, 1'b1, a, ~dq_in, dq_in, 4'hf, 4'hf);
		last_rd = 1'b1;
	endtask : read
endmodule : ddrsp_master_model

// [tb.sv]
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 4;
	logic                   mclk = 1'b0;
	logic                   resetn = 1'b0;
	logic                   run = 1'b1;
	logic                   ld_n, rw, oe, vld, eck;
	logic [AW-1:0]          a;
	ddrsp_pkg::ddrsp_mask_t bls;
	ddrsp_pkg::ddrsp_word_t din, dout, snap;
	ddrsp_pkg::ddrsp_word_t mem [32];
	ddrsp_pkg::ddrsp_word_t rq[$], eq[$];
	int                     err_count = 0;
	int                     checks_done = 0;
	int                     cyc = 0;

	ddrsp_master_model #(.ADDR_W(AW)) m (.mclk(mclk), .load_strobe_n(ld_n),
		.rw_sel(rw), .addr(a), .byte_lane_select_n(bls), .dq_in(din));
	ddrsp_port #(.ADDR_W(AW), .FIFO_DEPTH(16)) dut (.mclk(mclk),
		.resetn(resetn), .load_strobe_n(ld_n), .rw_sel(rw), .addr(a),
		.byte_lane_select_n(bls), .dq_in(din), .dq_out(dout), .dq_oe(oe),
		.output_valid_flag(vld), .echo_clk(eck));

	// clock parks high when stopped, for the quickest restart
	initial forever #2 if (run || !mclk) mclk = ~mclk;

	// collect every word the port drives
	always @(negedge mclk) if (oe === 1'b1) rq.push_back(dout);

	// hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic check(input ddrsp_pkg::ddrsp_word_t got, exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	function automatic ddrsp_pkg::ddrsp_word_t merge(
		input ddrsp_pkg::ddrsp_word_t o, n, input ddrsp_pkg::ddrsp_mask_t s);
		merge = o;
		for (int i = 0; i < 4; i++)
			if (!s[i]) merge[9*i +: 9] = n[9*i +: 9];
	endfunction : merge

	function automatic ddrsp_pkg::ddrsp_word_t pat(input int i);
		return 36'h3c3c3c3c3 + 36'(i) * 36'h111111111;
	endfunction : pat

	task automatic wr(input int i, input int p, input logic [3:0] m0, m1);
		m.write(i[AW-1:0], pat(p), m0, pat(p + 1), m1);
		mem[2*i] = merge(mem[2*i], pat(p), m0);
		mem[2*i+1] = merge(mem[2*i+1], pat(p + 1), m1);
	endtask : wr

	task automatic rd(input int i);
		eq.push_back(mem[2*i]);
		eq.push_back(mem[2*i+1]);
		m.read(i[AW-1:0]);
	endtask : rd

	// idle until all reads land, then compare in order
	task automatic drain(input string name);
		repeat (6) m.idle();
		check(rq.size(), eq.size());
		while (eq.size() > 0 && rq.size() > 0)
			check(rq.pop_front(), eq.pop_front());
		rq.delete();
		eq.delete();
		$display("test %s done", name);
	endtask : drain

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_idle();
		check(oe, 1'b0);
		check(vld, 1'b0);
		repeat (4) m.idle();
		check(rq.size(), 0);
		$display("test idle done");
	endtask : t_idle

	task automatic t_full();
		for (int i = 0; i < 4; i++)
			wr(i, 2 * i, 4'h0, 4'h0);
		for (int i = 0; i < 4; i++)
			rd(i);
		drain("full");
	endtask : t_full

	task automatic t_lanes();
		wr(4, 10, 4'h0, 4'h0);
		wr(5, 12, 4'h0, 4'h0);
		for (int i = 0; i < 4; i++)
			wr(4, 20 + 2 * i, ~(4'h1 << i), ~(4'h8 >> i));
		wr(5, 40, 4'hf, 4'hf);
		rd(4);
		rd(5);
		drain("lanes");
	endtask : t_lanes

	task automatic t_posted();
		wr(6, 50, 4'h0, 4'h0);
		rd(6);
		wr(7, 52, 4'h0, 4'h0);
		rd(6);
		rd(7);
		drain("posted");
	endtask : t_posted

	// flag leads the first word by one half cycle
	task automatic t_latency();
		rd(0);
		fork
			repeat (3) m.idle();
			for (int k = 0; k < 6; k++) begin
				@(negedge mclk);
				check(vld, 1'(6'b001100 >> k));
				check(oe, 1'(6'b011000 >> k));
				check(eck, 1'(6'b010101 >> k));
			end
		join
		drain("latency");
	endtask : t_latency

	// stop the clock while the second word is on the bus
	task automatic t_stop();
		rd(1);
		repeat (2) m.idle();
		run = 1'b0;
		@(posedge mclk);
		#1 snap = dout;
		#40;
		check(dout, snap);
		check(oe, 1'b1);
		run = 1'b1;
		repeat (2) @(negedge mclk);
		drain("stop");
	endtask : t_stop

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	// main sequence: reset release on a falling edge, next rise is k
	initial begin
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		resetn = 1'b1;
		t_idle();
		t_full();
		t_lanes();
		t_posted();
		t_latency();
		t_stop();
		stop_test();
	end
endmodule : tb
